// ---- bench/reg_packet_codec_tb_top.sv ----
`default_nettype none
module reg_packet_codec_tb_top;
  import reg_codec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, tx_valid, tx_last, tx_ready;
  logic rx_valid, rx_last, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  logic [15:0] tx_word, rx_word;
  logic [15:0] w [20];
  logic [127:0] key;
  link_meta_t  tx_meta, rx_meta;
  int          error_cnt = 0;
  int          n_compared = 0;
  reg_packet_codec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hready(hreadyout), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_word(tx_word), .tx_last(tx_last), .tx_meta(tx_meta),
    .rx_valid(rx_valid), .rx_word(rx_word), .rx_last(rx_last), .rx_meta(rx_meta));
  reg_peer_model peer (.hclk(hclk), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_word(tx_word), .tx_last(tx_last), .tx_meta(tx_meta), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_last(rx_last), .rx_meta(rx_meta));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  function automatic logic [15:0] w0(logic n, logic r, logic [1:0] s, logic [6:0] c,
                                     logic [2:0] k);
    return {n, r, s, 2'h0, c, k};
  endfunction
  // node-built frames: kind 0 request, 1 acknowledge, 2 unregistration
  task automatic tx_case(input logic [2:0] kd, input logic rm, input logic [1:0] sc,
                         input logic [6:0] cp, input logic ng, input logic r, input int n);
    bus(1'b1, OFS_CFG, {1'b0, cp, 6'h0, sc, 2'h0, 14'h0123});
    peer.cnt = 0;
    bus(1'b1, OFS_CTRL, {23'h0, rm, 1'b0, kd, 4'h1});
    for (int t = 0; t < 300 && peer.cnt < n; t++) @(posedge hclk);
    repeat (3) @(posedge hclk);
    check(32'(peer.cnt), 32'(n));
    check(32'(peer.last_at), 32'(n - 1));
    check(peer.cap[0], w0(ng, r, sc, cp, KEEPALIVE_ZERO));
    check({peer.cap[1], peer.cap[2], peer.cap[3]}, 48'h0123_89AB_CDEF);
    check(peer.meta, {1'b0, kd == 3'h0 ? NODE_ID_UNASSIGNED : 14'h0123});
    for (int i = 4; i < n; i++)
      check(peer.cap[i], i < 12 ? 16'h0000 : key[127 - 16 * (i - 12) -: 16]);
    $display("tx kind %0d sec %0d done", kd, sc);
  endtask
  initial begin
    repeat (30000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
  initial begin
    link_meta_t m [6];
    logic [15:0] hw [6];
    logic [2:0] kn [6];
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, OFS_CFG, 32'h0);
    check(q[13:0], NODE_ID_UNASSIGNED);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(q[6:4], 3'h7);
    bus(1'b1, 8'h80, 32'hFFFF_FFFF);
    bus(1'b0, 8'h80, 32'h0);
    check(q, 32'h0);
    bus(1'b1, OFS_ADDR_LO, 32'h89AB_CDEF);
    bus(1'b1, OFS_ADDR_HI, 32'h0000_0123);
    key = 128'hF00D_0004_BEEF_0003_CAFE_0002_5A5A_0001;
    for (int i = 0; i < 4; i++) bus(1'b1, OFS_TX_KEY + 8'(4 * i), key[32 * i +: 32]);
    // request with roaming kept, profile 3 carries no keys
    tx_case(3'h0, 1'b1, 2'h3, 7'h55, 1'b0, 1'b1, 4);
    // acknowledge under profile one against a stalling peer
    peer.stall = 1'b1;
    tx_case(3'h1, 1'b1, SEC_PROFILE1, 7'h2A, 1'b0, 1'b1, 20);
    peer.stall = 1'b0;
    tx_case(3'h1, 1'b0, SEC_NONE, 7'h7F, 1'b0, 1'b0, 4);
    tx_case(3'h2, 1'b1, SEC_NONE, 7'h01, 1'b1, 1'b0, 4);
    // frames as the base or a node would build them
    m = '{{1'b1, 14'h0012}, {1'b1, 14'h3FFF}, {1'b1, 14'h0012}, {1'b0, 14'h0005},
          {1'b0, 14'h3FFF}, {1'b0, 14'h0012}};
    hw = '{w0(0, 0, 1, 7'h7F, 5), w0(1, 0, 0, 7'h0, 0), w0(1, 0, 0, 7'h0, 0),
           w0(1, 0, 0, 7'h0, 0), w0(0, 1, 0, 7'h40, 0), w0(0, 0, 0, 7'h1, 0)};
    kn = '{3'h1, 3'h3, 3'h5, 3'h4, 3'h0, 3'h2};
    for (int i = 0; i < 20; i++) w[i] = 16'h1000 + 16'(i);
    for (int c = 0; c < 6; c++) begin
      w[0] = hw[c];
      peer.send(m[c], w, c == 0 ? 20 : 4);
      repeat (3) @(posedge hclk);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(q[6:4], kn[c]);
      check(q[1], 1'b1);
      check(q[2], 1'b0);
      bus(1'b0, OFS_RX_HDR0, 32'h0);
      check(q, {m[c].downlink_direction_bit, 1'b0, m[c].local_node_id, hw[c]});
      bus(1'b1, OFS_STATUS, 32'h2);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(q[1], 1'b0);
      if (c == 0) begin
        bus(1'b0, OFS_RX_KEY, 32'h0);
        check(q, {w[10], w[11]});
        bus(1'b0, OFS_RX_KEY + 8'h10, 32'h0);
        check(q, {w[18], w[19]});
      end
      $display("rx case %0d done", c);
    end
    bus(1'b0, OFS_RX_HDR1, 32'h0);
    check(q, {w[2], w[3]});
    summarize();
  end
endmodule
`default_nettype wire

// ---- bench/reg_peer_model.sv ----
`default_nettype none
module reg_peer_model
  import reg_codec_pkg::*;
(
  // clock
  input  wire logic        hclk,
  // frames from the codec
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [15:0] tx_word,
  input  wire logic        tx_last,
  input  wire link_meta_t  tx_meta,
  // frames toward the codec
  output logic             rx_valid,
  output logic [15:0]      rx_word,
  output logic             rx_last,
  output link_meta_t       rx_meta
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cap [20];
  link_meta_t  meta;
  int          cnt = 0;
  int          last_at = -1;
  logic        stall = 1'b0;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_word  = 16'hFFFF;
    rx_last  = 1'b0;
    rx_meta  = '0;
  end
  // slow mode drops ready every other cycle so words must wait
  always @(posedge hclk) begin
    tx_ready <= stall ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      if (cnt < 20) cap[cnt] <= tx_word;
      if (cnt == 0) meta <= tx_meta;
      if (tx_last) last_at <= cnt;
      cnt <= cnt + 1;
    end
  end
  // idle lines show the inverse of the last word, never a stale copy
  task automatic send(input link_meta_t m, input logic [15:0] w [20], input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      rx_valid <= 1'b1;
      rx_word  <= w[i];
      rx_last  <= (i == n - 1);
      rx_meta  <= m;
    end
    @(posedge hclk);
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_word  <= ~w[n-1];
    rx_meta  <= ~m;
  endtask
endmodule
`default_nettype wire

// ---- hw/reg_codec_pkg.sv ----
`default_nettype none
package reg_codec_pkg;
  localparam logic [13:0] NODE_ID_UNASSIGNED = 14'h3FFF;
  localparam int HDR_BITS  = 64;
  localparam int KEY_BITS  = 128;
  localparam int PKT_BITS  = HDR_BITS + 2 * KEY_BITS;
  localparam int WORD_BITS = 16;
  localparam logic [5:0] SHORT_WORDS = 6'h04;
  localparam logic [5:0] LONG_WORDS  = 6'h14;
  localparam logic [1:0] SEC_NONE     = 2'h0;
  localparam logic [1:0] SEC_PROFILE1 = 2'h1;
  localparam logic [2:0] KEEPALIVE_ZERO = 3'h0;
  localparam int KEEPALIVE_BASE_S = 32;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CFG      = 8'h04;
  localparam logic [7:0] OFS_ADDR_LO  = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_RX_HDR0  = 8'h14;
  localparam logic [7:0] OFS_RX_HDR1  = 8'h18;
  localparam logic [7:0] OFS_TX_KEY   = 8'h20;
  localparam logic [7:0] OFS_RX_KEY   = 8'h40;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum {
    MSG_REQUEST, MSG_RESPONSE, MSG_ACK, MSG_REJECT,
    MSG_UNREG_NODE, MSG_UNREG_BASE, MSG_INVALID
  } msg_kind_t;

  typedef struct packed {
    logic       negative;
    logic       roaming;
    logic [1:0] security_profile_cap;
    logic [1:0] reserved;
    logic       switch_capable;
    logic       aggregation_capable;
    logic       contention_free_capable;
    logic       direct_conn_capable;
    logic       multicast_capable;
    logic       robustness_mgmt_capable;
    logic       retransmit_conn_capable;
    logic [2:0] keepalive_wait;
    logic [47:0] node_hw_address;
  } reg_header_t;

  typedef struct packed {
    logic        downlink_direction_bit;
    logic [13:0] local_node_id;
  } link_meta_t;
endpackage
`default_nettype wire

// ---- hw/reg_packet_codec.sv ----
`default_nettype none
module reg_packet_codec
  import reg_codec_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        hready,
  // transmit side toward the link
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [15:0]      tx_word,
  output logic             tx_last,
  output link_meta_t       tx_meta,
  // receive side from the link
  input  wire logic        rx_valid,
  input  wire logic [15:0] rx_word,
  input  wire logic        rx_last,
  input  wire link_meta_t  rx_meta
);

  // decode of the six variants, used by the receive path only
  function automatic msg_kind_t classify(input logic dl, input logic [13:0] id,
                                         input logic neg, input logic roam);
    logic assigned;
    assigned = (id != NODE_ID_UNASSIGNED);
    if (!dl && !assigned && !neg) classify = MSG_REQUEST;
    else if (dl && assigned && !neg) classify = MSG_RESPONSE;
    else if (!dl && assigned && !neg) classify = MSG_ACK;
    else if (dl && !assigned && neg && !roam) classify = MSG_REJECT;
    else if (!dl && assigned && neg && !roam) classify = MSG_UNREG_NODE;
    else if (dl && assigned && neg && !roam) classify = MSG_UNREG_BASE;
    else classify = MSG_INVALID;
  endfunction

  function automatic logic keys_present(input msg_kind_t k, input logic [1:0] sp);
    keys_present = (k == MSG_RESPONSE || k == MSG_ACK) && (sp == SEC_PROFILE1);
  endfunction

  // software-written state
  logic [2:0]   cmd_kind_reg;      // 0 req,1 ack,2 unreg
  logic         cmd_roam_reg;
  logic [13:0]  cmd_node_id_reg;
  logic [1:0]   cmd_sec_reg;
  logic [6:0]   cmd_caps_reg;
  logic [47:0]  cmd_addr_reg;
  logic [127:0] tx_auk_reg;
  // status and receive capture
  logic         tx_busy_reg;
  logic         tx_done_reg;
  logic         rx_done_reg;
  logic         rx_bad_reg;
  logic [PKT_BITS-1:0] tx_shift_reg;
  logic [5:0]   tx_cnt_reg;
  logic [PKT_BITS-1:0] rx_buf_reg;
  logic [5:0]   rx_cnt_reg;
  link_meta_t   rx_meta_reg;
  logic [2:0]   rx_kind_reg;
  logic [PKT_BITS-1:0] rx_shift_next;
  reg_header_t  rx_hdr;

  // ahb address phase capture
  logic         ph_write_reg;
  logic         ph_active_reg;
  logic [7:0]   ph_addr_reg;
  logic         ph_take;

  assign ph_take   = hsel && hready && htrans == HTRANS_NONSEQ;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_active_reg <= 1'b0;
      ph_write_reg  <= 1'b0;
      ph_addr_reg   <= 8'h00;
    end else begin
      ph_active_reg <= ph_take;
      ph_write_reg  <= hwrite;
      ph_addr_reg   <= haddr;
    end
  end

  logic wr_en;
  logic start_tx;
  logic start_req_reg;
  assign wr_en    = ph_active_reg && ph_write_reg;
  assign start_tx = start_req_reg && !tx_busy_reg;

  // start acts a cycle late so the kind and roaming written with it are already held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_req_reg <= 1'b0;
    end else begin
      start_req_reg <= wr_en && ph_addr_reg == OFS_CTRL && hwdata[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_kind_reg    <= 3'h0;
      cmd_roam_reg    <= 1'b0;
      cmd_node_id_reg <= NODE_ID_UNASSIGNED;
      cmd_sec_reg     <= SEC_NONE;
      cmd_caps_reg    <= 7'h00;
      cmd_addr_reg    <= 48'h000000000000;
      tx_auk_reg      <= '0;
    end else if (wr_en) begin
      case (ph_addr_reg)
        OFS_CTRL: begin
          cmd_kind_reg <= hwdata[6:4];
          cmd_roam_reg <= hwdata[8];
        end
        OFS_CFG: begin
          cmd_node_id_reg <= hwdata[13:0];
          cmd_sec_reg     <= hwdata[17:16];
          cmd_caps_reg    <= hwdata[30:24];
        end
        OFS_ADDR_LO: cmd_addr_reg[31:0]  <= hwdata;
        OFS_ADDR_HI: cmd_addr_reg[47:32] <= hwdata[15:0];
        default: begin
          if (ph_addr_reg[7:4] == OFS_TX_KEY[7:4])
            tx_auk_reg[ph_addr_reg[3:2]*32 +: 32] <= hwdata;
        end
      endcase
    end
  end

  // frame assembly for the node-side variants
  reg_header_t tx_hdr;
  msg_kind_t   tx_kind;
  link_meta_t  tx_meta_next;
  always_comb begin
    tx_meta_next.downlink_direction_bit = 1'b0;
    tx_meta_next.local_node_id = NODE_ID_UNASSIGNED;
    tx_kind = MSG_REQUEST;
    case (cmd_kind_reg)
      3'h1: begin
        tx_kind = MSG_ACK;
        tx_meta_next.local_node_id = cmd_node_id_reg;
      end
      3'h2: begin
        tx_kind = MSG_UNREG_NODE;
        tx_meta_next.local_node_id = cmd_node_id_reg;
      end
      default: tx_kind = MSG_REQUEST;
    endcase
    tx_hdr.negative = (tx_kind == MSG_UNREG_NODE);
    tx_hdr.roaming  = (tx_kind == MSG_UNREG_NODE) ? 1'b0 : cmd_roam_reg;
    tx_hdr.security_profile_cap = cmd_sec_reg;
    tx_hdr.reserved = 2'h0;
    {tx_hdr.switch_capable, tx_hdr.aggregation_capable, tx_hdr.contention_free_capable,
     tx_hdr.direct_conn_capable, tx_hdr.multicast_capable, tx_hdr.robustness_mgmt_capable,
     tx_hdr.retransmit_conn_capable} = cmd_caps_reg;
    tx_hdr.keepalive_wait = KEEPALIVE_ZERO;
    tx_hdr.node_hw_address = cmd_addr_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= '0;
      tx_cnt_reg   <= 6'h00;
      tx_meta      <= '0;
    end else if (start_tx) begin
      tx_busy_reg <= 1'b1;
      tx_meta     <= tx_meta_next;
      // zero subnet key, auth key from software
      tx_shift_reg <= {tx_hdr, {KEY_BITS{1'b0}}, tx_auk_reg};
      tx_cnt_reg <= keys_present(tx_kind, cmd_sec_reg) ? LONG_WORDS : SHORT_WORDS;
    end else if (tx_busy_reg && tx_ready) begin
      tx_shift_reg <= {tx_shift_reg[PKT_BITS-WORD_BITS-1:0], {WORD_BITS{1'b0}}};
      tx_cnt_reg   <= tx_cnt_reg - 6'h01;
      if (tx_cnt_reg == 6'h01) tx_busy_reg <= 1'b0;
    end
  end

  assign tx_valid = tx_busy_reg;
  assign tx_word  = tx_shift_reg[PKT_BITS-1 -: WORD_BITS];
  assign tx_last  = tx_busy_reg && tx_cnt_reg == 6'h01;

  // receive capture, words packed msb first
  logic [5:0]          rx_words;
  logic [PKT_BITS-1:0] rx_frame;
  assign rx_shift_next = {rx_buf_reg[PKT_BITS-WORD_BITS-1:0], rx_word};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_reg  <= '0;
      rx_cnt_reg  <= 6'h00;
      rx_meta_reg <= '0;
    end else if (rx_valid) begin
      // keep the header at the top so a short frame reads back like a long one
      rx_buf_reg <= rx_last ? rx_frame : rx_shift_next;
      rx_cnt_reg <= rx_last ? 6'h00 : rx_cnt_reg + 6'h01;
      if (rx_last) rx_meta_reg <= rx_meta;
    end
  end

  // align a short frame so the header sits at the top
  reg_header_t rx_hdr_now;
  msg_kind_t rx_kind_now;
  assign rx_words = rx_cnt_reg + 6'h01;
  assign rx_frame = (rx_words == SHORT_WORDS) ?
                    {rx_shift_next[HDR_BITS-1:0], {(2*KEY_BITS){1'b0}}} : rx_shift_next;
  assign rx_hdr_now  = reg_header_t'(rx_frame[PKT_BITS-1 -: HDR_BITS]);
  assign rx_kind_now = classify(rx_meta.downlink_direction_bit, rx_meta.local_node_id,
                                rx_hdr_now.negative, rx_hdr_now.roaming);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_kind_reg <= 3'h7;
      rx_bad_reg  <= 1'b0;
      rx_done_reg <= 1'b0;
      tx_done_reg <= 1'b0;
    end else begin
      if (rx_valid && rx_last) begin
        rx_done_reg <= 1'b1;
        rx_kind_reg <= 3'(rx_kind_now);
        rx_bad_reg  <= rx_kind_now == MSG_INVALID ||
                       (rx_words != (keys_present(rx_kind_now,
                         rx_hdr_now.security_profile_cap) ? LONG_WORDS : SHORT_WORDS));
      end else if (wr_en && ph_addr_reg == OFS_STATUS && hwdata[1]) begin
        rx_done_reg <= 1'b0;
      end
      if (tx_busy_reg && tx_ready && tx_cnt_reg == 6'h01) tx_done_reg <= 1'b1;
      else if (wr_en && ph_addr_reg == OFS_STATUS && hwdata[0]) tx_done_reg <= 1'b0;
    end
  end

  assign rx_hdr = reg_header_t'(rx_buf_reg[PKT_BITS-1 -: HDR_BITS]);
  logic [127:0] rx_key;
  logic [31:0]  rd_next;
  assign rx_key = ph_addr_reg[4] ? rx_buf_reg[KEY_BITS-1:0]
                                 : rx_buf_reg[2*KEY_BITS-1:KEY_BITS];
  always_comb begin
    rd_next = 32'h00000000;
    case (ph_addr_reg)
      OFS_CTRL:    rd_next = {23'h0, cmd_roam_reg, 1'b0, cmd_kind_reg, 3'h0, tx_busy_reg};
      OFS_CFG:     rd_next = {1'b0, cmd_caps_reg, 6'h0, cmd_sec_reg, 2'h0, cmd_node_id_reg};
      OFS_ADDR_LO: rd_next = cmd_addr_reg[31:0];
      OFS_ADDR_HI: rd_next = {16'h0, cmd_addr_reg[47:32]};
      OFS_STATUS:  rd_next = {25'h0, rx_kind_reg, 1'b0, rx_bad_reg, rx_done_reg, tx_done_reg};
      // keepalive code of a response exposed for the timer
      OFS_RX_HDR0: rd_next = {rx_meta_reg.downlink_direction_bit, 1'b0,
                              rx_meta_reg.local_node_id, rx_hdr[63:48]};
      OFS_RX_HDR1: rd_next = rx_hdr[31:0];
      default: begin
        if (ph_addr_reg[7:5] == OFS_RX_KEY[7:5])
          rd_next = rx_key[ph_addr_reg[3:2]*32 +: 32];
      end
    endcase
  end
  assign hrdata = rd_next;

  request_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx && cmd_kind_reg == 3'h0 |=> tx_meta.local_node_id == NODE_ID_UNASSIGNED
      && !tx_meta.downlink_direction_bit && !tx_word[15]) else $error("bad request");
  ack_frame_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx && cmd_kind_reg == 3'h1 |=> tx_meta.local_node_id == cmd_node_id_reg
      && !tx_word[15]) else $error("bad ack");
  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx |=> tx_word[11:10] == 2'h0) else $error("reserved set");
  sequence long_start_s;
    start_tx && cmd_kind_reg == 3'h1 && cmd_sec_reg == SEC_PROFILE1;
  endsequence
  key_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
    long_start_s |=> tx_cnt_reg == LONG_WORDS) else $error("keys missing");
  short_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx && cmd_kind_reg != 3'h1 |=> tx_cnt_reg == SHORT_WORDS)
    else $error("keys present");
  subnet_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    long_start_s |=> tx_shift_reg[2*KEY_BITS-1:KEY_BITS] == '0) else $error("snk set");
  keepalive_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx |=> tx_word[2:0] == KEEPALIVE_ZERO) else $error("keepalive nonzero");
  unreg_flags_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx && cmd_kind_reg == 3'h2 |=> tx_word[15:14] == 2'b10) else $error("unreg");
  address_msb_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_tx |=> tx_shift_reg[PKT_BITS-17 -: 16] == $past(cmd_addr_reg[47:32]))
    else $error("address order");
endmodule
`default_nettype wire
